// ===== design/osc_interval_timer.sv
// Retriggerable interval timer holding an output high for a cycle count
`timescale 1ns/1ps

module osc_interval_timer
  import osc_pkg::*;
#(
  parameter int CNT_W = TIM_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic [CNT_W-1:0] cycles,
  // Status
  output logic active
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic active;
  } osc_tim_st_t;

  osc_tim_st_t s_q;
  osc_tim_st_t s_d;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Start reloads the count; otherwise count down to zero
  always_comb begin
    s_d = s_q;
    if (start && cycles != '0) begin
      s_d.cnt = cycles - CNT_W'(1);
      s_d.active = 1'b1;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - CNT_W'(1);
    end else begin
      s_d.active = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign active = s_q.active;

endmodule : osc_interval_timer

// ===== design/osc_stage_regs.sv
// Output stage configuration registers, status word and alarm gating
`timescale 1ns/1ps

// Notes on behaviour
// [R1] Enable bits 0-2 gate overcurrent and thermal faults
// [R2] Enable bits 3-5 gate undervoltages and stall
// [R3] Enabled fault raises internal alarm to processor
// [R4] Critical-discharge stop ignores the fault reset
// [R5] Gate config one fields; other bits ignored
// [R6] Gate current code decodes to 4..96 mA
// [R7] Charge time (code+1)x125 ns, saturates 3750
// [R8] Extra off-time code selects 0..1000 ns
// [R9] Gate config two: blanking 7:5, dead 4:0
// [R10] Dead time (code+1)x125 ns before switch-on
// [R11] Comparators blanked (code+1)x125 ns after switching
// [R12] Upper status byte flag order fixed
// [R13] Float flag 1 when all bridge transistors off
// [R14] Supply undervoltage flags active low
// [R15] Overcurrent flag active low
// [R16] Stall flags active low, voltage mode only
// [R17] Thermal state two-bit code
// [R18] Busy flag 0 when command not executable
// [R19] Step-clock flag 1 in step-clock mode
// [R20] Direction flag 1 direct, 0 inverse
// [R21] Motion phase two-bit code
// [R22] Control mode select: 1 current, 0 voltage
// [R23] Reserved enable bits ignored; disabled faults silent
// [R24] Status is read-only; writes rejected
module osc_stage_regs
  import osc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Object dictionary access
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_index,
  input wire logic [15:0] req_wdata,
  output logic ack_q,
  output logic err_q,
  output logic [15:0] rdata_q,
  // Output stage state pins
  input wire logic bridge_float_flag,
  input wire logic gate_supply_low_flag_n,
  input wire logic measured_supply_low_flag_n,
  input wire logic overcurrent_flag_n,
  input wire logic stall_a_flag_n,
  input wire logic stall_b_flag_n,
  input wire logic [1:0] thermal_state,
  input wire logic busy_flag_n,
  input wire logic step_clock_mode_flag,
  input wire logic direction_flag,
  input wire logic [1:0] motion_phase,
  input wire logic crit_discharge,
  input wire logic switch_event,
  // Controller side
  input wire logic control_mode_select,
  input wire logic fault_reset_req,
  output logic alarm_q,
  output logic motor_stop_q,
  // Gate drive settings
  output logic [6:0] gate_current_ma_q,
  output logic [TIM_W-1:0] charge_time_cycles_q,
  output logic [TIM_W-1:0] extra_off_cycles_q,
  output logic dead_time_active_q,
  output logic comp_blank_q
);

  typedef struct packed {
    logic [15:0] pin_s1;
    logic [15:0] pin_s2;
    logic [2:0] sw_sh;
    logic [7:0] alarm_en;
    logic [15:0] gate_one;
    logic [7:0] gate_two;
    logic [15:0] status;
    logic alarm;
    logic crit_stop;
    logic ack;
    logic err;
    logic [15:0] rdata;
    logic [6:0] gc_ma;
    logic [TIM_W-1:0] ct_cyc;
    logic [TIM_W-1:0] eo_cyc;
  } osc_regs_st_t;

  osc_regs_st_t s_q;
  osc_regs_st_t s_d;
  logic [15:0] pin_raw;
  logic [15:0] pin_now;
  logic [5:0] fault_vec;
  logic sw_pulse;
  logic [TIM_W-1:0] dt_cycles;
  logic [TIM_W-1:0] bl_cycles;
  logic dt_active;
  logic bl_active;

  // ---------------------------------------------------------------
  // Pin gathering in status layout
  // ---------------------------------------------------------------
  // Raw pins placed at their status word positions
  always_comb begin
    pin_raw = '0;
    pin_raw[ST_STALL_A] = stall_a_flag_n;
    pin_raw[ST_STALL_B] = stall_b_flag_n;
    pin_raw[ST_OVERCUR] = overcurrent_flag_n;
    pin_raw[ST_THERM_LSB +: 2] = thermal_state;
    pin_raw[ST_MEAS_LOW] = measured_supply_low_flag_n;
    pin_raw[ST_GATE_LOW] = gate_supply_low_flag_n;
    pin_raw[ST_STEP_CLK] = step_clock_mode_flag;
    pin_raw[ST_MOTION_LSB +: 2] = motion_phase;
    pin_raw[ST_DIR] = direction_flag;
    pin_raw[ST_BUSY] = busy_flag_n;
    pin_raw[ST_FLOAT] = bridge_float_flag;
    pin_raw[0] = crit_discharge;
  end

  // Stall flags forced inactive in current control mode
  always_comb begin
    pin_now = s_q.pin_s2;
    if (control_mode_select) begin // [R22]
      pin_now[ST_STALL_A] = 1'b1; // [R16]
      pin_now[ST_STALL_B] = 1'b1; // [R16]
    end
  end

  // ---------------------------------------------------------------
  // Fault sources, active high
  // ---------------------------------------------------------------
  // Active-low flags inverted into fault requests
  always_comb begin
    fault_vec = '0;
    fault_vec[AL_OVERCUR] = ~pin_now[ST_OVERCUR]; // [R1] [R15]
    fault_vec[AL_THERM_SHUT] = pin_now[ST_THERM_LSB + 1]; // [R1] [R17]
    fault_vec[AL_THERM_WARN] = pin_now[ST_THERM_LSB] | pin_now[ST_THERM_LSB + 1]; // [R1]
    fault_vec[AL_GATE_LOW] = ~pin_now[ST_GATE_LOW]; // [R2] [R14]
    fault_vec[AL_MEAS_LOW] = ~pin_now[ST_MEAS_LOW]; // [R2] [R14]
    fault_vec[AL_STALL] = ~(pin_now[ST_STALL_A] & pin_now[ST_STALL_B]); // [R2] [R16]
  end

  // Rising edge of the synchronised switching event
  assign sw_pulse = s_q.sw_sh[1] & ~s_q.sw_sh[2];

  // Timer lengths from gate config two
  assign dt_cycles = ps_to_cycles((int'(s_q.gate_two[DT_LSB +: 5]) + 1) * STEP_PS); // [R10]
  assign bl_cycles = ps_to_cycles((int'(s_q.gate_two[BL_LSB +: 3]) + 1) * STEP_PS); // [R11]

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [4:0] ct_code;
    ct_code = '0;
    s_d = s_q;
    // Two-stage pin synchroniser
    s_d.pin_s1 = pin_raw;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.sw_sh = {s_q.sw_sh[1:0], switch_event};
    // Status word follows the stage continuously
    s_d.status = pin_now & STATUS_USED; // [R12] [R13] [R18] [R19] [R20] [R21] [R24]
    // Alarm: fault reset clears, an enabled fault sets and wins
    if (fault_reset_req) begin
      s_d.alarm = 1'b0;
    end
    if (|(fault_vec & s_q.alarm_en[5:0])) begin // [R3] [R23]
      s_d.alarm = 1'b1;
    end
    // Critical discharge stop clears only on reset
    if (s_q.pin_s2[0]) begin
      s_d.crit_stop = 1'b1; // [R4]
    end
    // Register access
    s_d.ack = 1'b0;
    s_d.err = 1'b0;
    if (req_valid) begin
      s_d.ack = 1'b1;
      unique case (req_index)
        IDX_ALARM_EN: begin
          s_d.rdata = {8'h00, s_q.alarm_en};
          if (req_write) begin
            s_d.alarm_en = req_wdata[7:0] & MASK_ALARM_EN; // [R23]
          end
        end
        IDX_GATE_ONE: begin
          s_d.rdata = s_q.gate_one;
          if (req_write) begin
            s_d.gate_one = req_wdata & MASK_GATE_ONE; // [R5]
          end
        end
        IDX_GATE_TWO: begin
          s_d.rdata = {8'h00, s_q.gate_two};
          if (req_write) begin
            s_d.gate_two = req_wdata[7:0]; // [R9]
          end
        end
        IDX_STATUS: begin
          s_d.rdata = s_q.status;
          s_d.err = req_write; // [R24]
        end
        default: begin
          s_d.rdata = 16'h0000;
          s_d.err = 1'b1;
        end
      endcase
    end
    // Gate drive decode
    s_d.gc_ma = 7'(GC_MA[s_q.gate_one[GC_LSB +: 3]]); // [R6]
    ct_code = s_q.gate_one[CT_LSB +: 5];
    if (ct_code > CT_SAT_CODE) begin
      ct_code = CT_SAT_CODE; // [R7]
    end
    s_d.ct_cyc = ps_to_cycles((int'(ct_code) + 1) * STEP_PS); // [R7]
    s_d.eo_cyc = ps_to_cycles(EO_PS[s_q.gate_one[EO_LSB +: 3]]); // [R8]
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.pin_s1 <= STATUS_IDLE;
      s_q.pin_s2 <= STATUS_IDLE;
      s_q.status <= STATUS_IDLE & STATUS_USED;
      s_q.alarm_en <= RST_ALARM_EN;
      s_q.gate_one <= RST_GATE_ONE;
      s_q.gate_two <= RST_GATE_TWO;
      // Decoded settings already match the reset gate config
      s_q.gc_ma <= 7'(GC_MA[RST_GATE_ONE[GC_LSB +: 3]]); // [R6]
      s_q.ct_cyc <= ps_to_cycles((int'(RST_GATE_ONE[CT_LSB +: 5]) + 1) * STEP_PS); // [R7]
      s_q.eo_cyc <= ps_to_cycles(EO_PS[RST_GATE_ONE[EO_LSB +: 3]]); // [R8]
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Dead time and comparator blanking timers
  // ---------------------------------------------------------------
  osc_interval_timer #(
    .CNT_W(TIM_W)
  ) u_dead (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(sw_pulse), // [R10]
    .cycles(dt_cycles),
    .active(dt_active)
  );

  osc_interval_timer #(
    .CNT_W(TIM_W)
  ) u_blank (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(sw_pulse), // [R11]
    .cycles(bl_cycles),
    .active(bl_active)
  );

  // Outputs straight from flip-flops
  assign ack_q = s_q.ack;
  assign err_q = s_q.err;
  assign rdata_q = s_q.rdata;
  assign alarm_q = s_q.alarm;
  assign motor_stop_q = s_q.crit_stop;
  assign gate_current_ma_q = s_q.gc_ma;
  assign charge_time_cycles_q = s_q.ct_cyc;
  assign extra_off_cycles_q = s_q.eo_cyc;
  assign dead_time_active_q = dt_active;
  assign comp_blank_q = bl_active;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Cycles the blanking window has stood since the last switching pulse
  logic [7:0] hold_cnt;
  always_ff @(posedge sys_clk) begin
    if (rst || sw_pulse) begin
      hold_cnt <= '0;
    end else if (bl_active && hold_cnt != 8'hFF) begin
      hold_cnt <= hold_cnt + 8'h01;
    end
  end

  // Cycles the dead-time window has stood since the last switching pulse
  logic [7:0] dead_cnt;
  always_ff @(posedge sys_clk) begin
    if (rst || sw_pulse) begin
      dead_cnt <= '0;
    end else if (dt_active && dead_cnt != 8'hFF) begin
      dead_cnt <= dead_cnt + 8'h01;
    end
  end

  a_alarm_from_fault: assert property ( // [R3]
    |(fault_vec & s_q.alarm_en[5:0]) |=> alarm_q)
    else $error("enabled fault did not raise alarm");
  a_alarm_quiet_off: assert property ( // [R23]
    (fault_reset_req && !(|(fault_vec & s_q.alarm_en[5:0]))) |=> !alarm_q)
    else $error("alarm held with no enabled fault after reset request");
  a_crit_stop_sticky: assert property ( // [R4]
    motor_stop_q |=> motor_stop_q)
    else $error("critical stop released without reset");
  a_reserved_alarm_en: assert property ( // [R23]
    s_q.alarm_en[7:6] == 2'b00)
    else $error("reserved enable bits stored");
  a_status_write_err: assert property ( // [R24]
    (req_valid && req_write && req_index == IDX_STATUS) |=> (err_q && ack_q))
    else $error("status write not rejected");
  a_gate_one_mask: assert property ( // [R5]
    s_q.gate_one[15:11] == 5'h00)
    else $error("ignored gate config bits stored");
  a_charge_sat: assert property ( // [R7]
    (s_q.gate_one[4:0] >= CT_SAT_CODE) |=>
      (charge_time_cycles_q == ps_to_cycles(CT_MAX_NS * 1000)))
    else $error("charge time not saturated");
  a_blank_length: assert property ( // [R11]
    $fell(bl_active) |-> (hold_cnt == 8'(bl_cycles)))
    else $error("blanking length wrong");
  a_dead_length: assert property ( // [R10]
    $fell(dt_active) |-> (dead_cnt == 8'(dt_cycles)))
    else $error("dead time length wrong");
  a_dead_start: assert property ( // [R10]
    sw_pulse |=> dt_active)
    else $error("dead time did not start on switching");
  a_stall_mask: assert property ( // [R16]
    (control_mode_select && $stable(control_mode_select)) |=>
      (s_q.status[ST_STALL_A] && s_q.status[ST_STALL_B]))
    else $error("stall flag active in current mode");
  a_crit_stop_set: assert property ( // [R4]
    s_q.pin_s2[0] |=> motor_stop_q)
    else $error("critical discharge did not stop the motor");
  a_err_with_ack: assert property ( // [R24]
    err_q |-> ack_q)
    else $error("rejection flagged without an answer");
  a_float_status: assert property ( // [R13]
    !rst |=> (s_q.status[ST_FLOAT] == $past(s_q.pin_s2[ST_FLOAT])))
    else $error("float flag does not follow the stage");

  c_alarm_raise: cover property ($rose(alarm_q));
  c_status_read: cover property (req_valid && !req_write && req_index == IDX_STATUS);
  c_switch_blank: cover property (sw_pulse ##1 bl_active [*3]);
  c_crit_stop: cover property ($rose(motor_stop_q));
  c_alarm_clear: cover property ($fell(alarm_q));

endmodule : osc_stage_regs

// ===== include/osc_pkg.sv
// Constants shared by the output stage configuration and status bank
package osc_pkg;

  // ---------------------------------------------------------------
  // Register indices (object sub-index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_ALARM_EN = 8'h06;
  localparam logic [7:0] IDX_GATE_ONE = 8'h07;
  localparam logic [7:0] IDX_GATE_TWO = 8'h08;
  localparam logic [7:0] IDX_STATUS = 8'h09;

  // ---------------------------------------------------------------
  // Reset values and write masks
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_ALARM_EN = 8'h0B;
  localparam logic [15:0] RST_GATE_ONE = 16'h00E2;
  localparam logic [7:0] RST_GATE_TWO = 8'h20;
  localparam logic [7:0] MASK_ALARM_EN = 8'h3F;
  localparam logic [15:0] MASK_GATE_ONE = 16'h07FF;
  localparam logic [15:0] STATUS_IDLE = 16'hE604;
  localparam logic [15:0] STATUS_USED = 16'hFFE6;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int GC_LSB = 5;
  localparam int CT_LSB = 0;
  localparam int EO_LSB = 8;
  localparam int BL_LSB = 5;
  localparam int DT_LSB = 0;
  localparam int ST_STALL_A = 15;
  localparam int ST_STALL_B = 14;
  localparam int ST_OVERCUR = 13;
  localparam int ST_THERM_LSB = 11;
  localparam int ST_MEAS_LOW = 10;
  localparam int ST_GATE_LOW = 9;
  localparam int ST_STEP_CLK = 8;
  localparam int ST_MOTION_LSB = 6;
  localparam int ST_DIR = 5;
  localparam int ST_BUSY = 2;
  localparam int ST_FLOAT = 1;

  // ---------------------------------------------------------------
  // Alarm enable bit positions
  // ---------------------------------------------------------------
  localparam int AL_OVERCUR = 0;
  localparam int AL_THERM_SHUT = 1;
  localparam int AL_THERM_WARN = 2;
  localparam int AL_GATE_LOW = 3;
  localparam int AL_MEAS_LOW = 4;
  localparam int AL_STALL = 5;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 100000;
  localparam int STEP_PS = 125000;
  localparam logic [4:0] CT_SAT_CODE = 5'h1D;
  localparam int CT_MAX_NS = 3750;
  localparam int DT_MAX_NS = 4000;
  // Extra off-time per code, in picoseconds
  localparam int EO_PS [8] = '{0, 62500, 125000, 250000, 375000, 500000, 750000, 1000000};
  // Gate drive current per code, in mA
  localparam int GC_MA [8] = '{4, 4, 8, 16, 24, 32, 64, 96};
  localparam int TIM_W = 6;

  // Least time in picoseconds to whole clock cycles, rounded up
  function automatic logic [TIM_W-1:0] ps_to_cycles(input int ps);
    return TIM_W'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  endfunction : ps_to_cycles

endpackage : osc_pkg

// ===== test/osc_stage_model.sv
// Behavioural output stage that drives the status, fault and event pins
`timescale 1ns/1ps

module osc_stage_model
  import osc_pkg::*;
(
  // Clock and bench commands
  input wire logic sys_clk,
  input wire logic [15:0] pin_img,
  input wire logic crit_cmd,
  input wire logic sw_cmd,
  // Stage pins
  output logic bridge_float_flag,
  output logic gate_supply_low_flag_n,
  output logic measured_supply_low_flag_n,
  output logic overcurrent_flag_n,
  output logic stall_a_flag_n,
  output logic stall_b_flag_n,
  output logic [1:0] thermal_state,
  output logic busy_flag_n,
  output logic step_clock_mode_flag,
  output logic direction_flag,
  output logic [1:0] motion_phase,
  output logic crit_discharge,
  output logic switch_event
);
  // -------------------------------------------------------------
  // Stage state
  // -------------------------------------------------------------
  logic [15:0] img_q = STATUS_IDLE;
  logic crit_q = 1'b0;
  logic [2:0] sw_cnt_q = 3'h0;

  // Pins move one clock after the command, as a real stage lags its control
  always_ff @(posedge sys_clk) begin
    img_q <= pin_img;
    crit_q <= crit_cmd;
    if (sw_cmd) begin
      sw_cnt_q <= 3'h4;
    end else if (sw_cnt_q != 3'h0) begin
      sw_cnt_q <= sw_cnt_q - 3'h1;
    end
  end

  // Flag pins laid out as the status word reports them
  assign stall_a_flag_n = img_q[ST_STALL_A];
  assign stall_b_flag_n = img_q[ST_STALL_B];
  assign overcurrent_flag_n = img_q[ST_OVERCUR];
  assign thermal_state = img_q[ST_THERM_LSB +: 2];
  assign measured_supply_low_flag_n = img_q[ST_MEAS_LOW];
  assign gate_supply_low_flag_n = img_q[ST_GATE_LOW];
  assign step_clock_mode_flag = img_q[ST_STEP_CLK];
  assign motion_phase = img_q[ST_MOTION_LSB +: 2];
  assign direction_flag = img_q[ST_DIR];
  assign busy_flag_n = img_q[ST_BUSY];
  assign bridge_float_flag = img_q[ST_FLOAT];
  assign crit_discharge = crit_q;
  // Switching event held long enough to pass the pin synchroniser
  assign switch_event = (sw_cnt_q != 3'h0);
endmodule : osc_stage_model

// ===== test/tb.sv
// Self-checking bench for the output stage register bank
`timescale 1ns/1ps

module tb
  import osc_pkg::*;
;
  // -------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------
  typedef struct {logic err; logic rd; logic [15:0] data;} osc_exp_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0;
  logic [7:0] req_index = 8'h00;
  logic [15:0] req_wdata = 16'h0000, pin_img = STATUS_IDLE;
  logic control_mode_select = 1'b0, fault_reset_req = 1'b0, crit_cmd = 1'b0, sw_cmd = 1'b0;
  logic ack_q, err_q, alarm_q, motor_stop_q, dead_time_active_q, comp_blank_q;
  logic [15:0] rdata_q;
  logic [6:0] gate_current_ma_q;
  logic [TIM_W-1:0] charge_time_cycles_q, extra_off_cycles_q;
  logic bridge_float_flag, gate_supply_low_flag_n, measured_supply_low_flag_n;
  logic overcurrent_flag_n, stall_a_flag_n, stall_b_flag_n, busy_flag_n;
  logic step_clock_mode_flag, direction_flag, crit_discharge, switch_event;
  logic [1:0] thermal_state, motion_phase;
  int bad_count = 0, num_checks = 0, cycles = 0, seed = 32'hBE42;
  int gc_exp [8] = '{4, 4, 8, 16, 24, 32, 64, 96};
  int eo_exp [8] = '{0, 1, 2, 3, 4, 5, 8, 10};
  logic [15:0] src [6] = '{16'h2000, 16'h1000, 16'h0800, 16'h0200, 16'h0400, 16'h8000};
  osc_exp_t exp_q [$];
  osc_exp_t mon_e;

  // Clock generator
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // -------------------------------------------------------------
  // Design and stage model
  // -------------------------------------------------------------
  osc_stage_regs dut_u (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_index(req_index), .req_wdata(req_wdata), .ack_q(ack_q),
    .err_q(err_q), .rdata_q(rdata_q), .bridge_float_flag(bridge_float_flag),
    .gate_supply_low_flag_n(gate_supply_low_flag_n),
    .measured_supply_low_flag_n(measured_supply_low_flag_n),
    .overcurrent_flag_n(overcurrent_flag_n), .stall_a_flag_n(stall_a_flag_n),
    .stall_b_flag_n(stall_b_flag_n), .thermal_state(thermal_state),
    .busy_flag_n(busy_flag_n), .step_clock_mode_flag(step_clock_mode_flag),
    .direction_flag(direction_flag), .motion_phase(motion_phase),
    .crit_discharge(crit_discharge), .switch_event(switch_event),
    .control_mode_select(control_mode_select), .fault_reset_req(fault_reset_req),
    .alarm_q(alarm_q), .motor_stop_q(motor_stop_q), .gate_current_ma_q(gate_current_ma_q),
    .charge_time_cycles_q(charge_time_cycles_q), .extra_off_cycles_q(extra_off_cycles_q),
    .dead_time_active_q(dead_time_active_q), .comp_blank_q(comp_blank_q));

  osc_stage_model model_u (.sys_clk(sys_clk), .pin_img(pin_img), .crit_cmd(crit_cmd),
    .sw_cmd(sw_cmd), .bridge_float_flag(bridge_float_flag),
    .gate_supply_low_flag_n(gate_supply_low_flag_n),
    .measured_supply_low_flag_n(measured_supply_low_flag_n),
    .overcurrent_flag_n(overcurrent_flag_n), .stall_a_flag_n(stall_a_flag_n),
    .stall_b_flag_n(stall_b_flag_n), .thermal_state(thermal_state),
    .busy_flag_n(busy_flag_n), .step_clock_mode_flag(step_clock_mode_flag),
    .direction_flag(direction_flag), .motion_phase(motion_phase),
    .crit_discharge(crit_discharge), .switch_event(switch_event));

  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // One access; the expected answer is noted for the monitor
  task automatic acc(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                     input logic err, input logic [15:0] rd);
    exp_q.push_back('{err, !wr, rd});
    req_write = wr;
    req_index = idx;
    req_wdata = wd;
    req_valid = 1'b1;
    cyc(1);
    req_valid = 1'b0;
    cyc(1);
  endtask : acc

  task automatic pulse_clear();
    fault_reset_req = 1'b1;
    cyc(1);
    fault_reset_req = 1'b0;
    cyc(1);
  endtask : pulse_clear

  task automatic do_reset();
    rst = 1'b1;
    cyc(8);
    rst = 1'b0;
    cyc(1);
  endtask : do_reset

  // Status image as read back; stall flags stay inactive in current mode
  function automatic logic [15:0] exp_st(input logic [15:0] img, input logic cm);
    return (img & STATUS_USED) | (cm ? 16'hC000 : 16'h0000);
  endfunction : exp_st

  task automatic test_done();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // Monitor: each answer is matched against the oldest note
  always @(negedge sys_clk) begin
    if (ack_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(16'h0001, 16'h0000, "answer without request");
      end else begin
        mon_e = exp_q.pop_front();
        chk(16'(err_q), 16'(mon_e.err), "error flag");
        if (mon_e.rd) begin
          chk(rdata_q, mon_e.data, "read data");
        end
      end
    end
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [15:0] w;
    logic [7:0] m;
    int tc, dc, bc;
    do_reset();
    acc(1'b0, IDX_ALARM_EN, 16'h0000, 1'b0, 16'h000B);
    acc(1'b0, IDX_GATE_ONE, 16'h0000, 1'b0, 16'h00E2);
    acc(1'b0, IDX_GATE_TWO, 16'h0000, 1'b0, 16'h0020);
    acc(1'b0, IDX_STATUS, 16'h0000, 1'b0, STATUS_IDLE & STATUS_USED);
    chk(16'(gate_current_ma_q), 16'h0060, "reset gate current");
    chk(16'(charge_time_cycles_q), 16'h0004, "reset charge time");
    // Refused and reserved accesses
    acc(1'b1, IDX_STATUS, 16'h0000, 1'b1, 16'h0000);
    acc(1'b0, IDX_STATUS, 16'h0000, 1'b0, STATUS_IDLE);
    acc(1'b0, 8'h05, 16'h0000, 1'b1, 16'h0000);
    acc(1'b1, 8'h0A, 16'hFFFF, 1'b1, 16'h0000);
    acc(1'b1, IDX_ALARM_EN, 16'hFFFF, 1'b0, 16'h0000);
    acc(1'b0, IDX_ALARM_EN, 16'h0000, 1'b0, 16'h003F);
    // Gate config one over every field code
    for (int i = 0; i < 32; i++) begin
      r = $random(seed);
      w = {r[15:11], i[2:0], i[2:0], i[4:0]};
      acc(1'b1, IDX_GATE_ONE, w, 1'b0, 16'h0000);
      acc(1'b0, IDX_GATE_ONE, 16'h0000, 1'b0, w & 16'h07FF);
      tc = (i > 29 ? 29 : i) + 1;
      chk(16'(gate_current_ma_q), 16'(gc_exp[i % 8]), "gate current");
      chk(16'(charge_time_cycles_q), 16'((tc * 125 + 99) / 100), "charge time");
      chk(16'(extra_off_cycles_q), 16'(eo_exp[i % 8]), "extra off time");
    end
    // Gate config two: dead and blanking windows after a switching event
    for (int k = 0; k < 8; k++) begin
      w = {8'h00, k[2:0], k[1:0], k[2:0]};
      acc(1'b1, IDX_GATE_TWO, w, 1'b0, 16'h0000);
      acc(1'b0, IDX_GATE_TWO, 16'h0000, 1'b0, w);
      sw_cmd = 1'b1;
      cyc(1);
      sw_cmd = 1'b0;
      dc = 0;
      bc = 0;
      for (int j = 0; j < 60; j++) begin
        dc += (dead_time_active_q === 1'b1) ? 1 : 0;
        bc += (comp_blank_q === 1'b1) ? 1 : 0;
        cyc(1);
      end
      tc = int'(w[4:0]) + 1;
      chk(16'(dc), 16'((tc * 125 + 99) / 100), "dead time");
      tc = int'(w[7:5]) + 1;
      chk(16'(bc), 16'((tc * 125 + 99) / 100), "blanking time");
    end
    // Each fault source: silent while masked, alarm when enabled
    for (int b = 0; b < 6; b++) begin
      m = (b == 1) ? 8'h39 : (8'h3F ^ (8'h01 << b));
      acc(1'b1, IDX_ALARM_EN, {8'h00, m}, 1'b0, 16'h0000);
      pin_img = STATUS_IDLE ^ src[b];
      cyc(5);
      chk(16'(alarm_q), 16'h0000, "alarm while masked");
      acc(1'b0, IDX_STATUS, 16'h0000, 1'b0, pin_img & STATUS_USED);
      acc(1'b1, IDX_ALARM_EN, {8'h00, 8'h01 << b}, 1'b0, 16'h0000);
      cyc(5);
      chk(16'(alarm_q), 16'h0001, "alarm on fault");
      pulse_clear();
      chk(16'(alarm_q), 16'h0001, "alarm kept while fault stands");
      pin_img = STATUS_IDLE;
      cyc(5);
      pulse_clear();
      cyc(1);
      chk(16'(alarm_q), 16'h0000, "alarm cleared");
    end
    // Random stage states with every alarm masked
    acc(1'b1, IDX_ALARM_EN, 16'h0000, 1'b0, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      pin_img = r[15:0];
      control_mode_select = r[16];
      cyc(5);
      w = exp_st(r[15:0], r[16]);
      acc(1'b0, IDX_STATUS, 16'h0000, 1'b0, w);
      chk(16'(alarm_q), 16'h0000, "alarm with all masked");
    end
    control_mode_select = 1'b0;
    pin_img = STATUS_IDLE;
    // Critical discharge stop survives the fault reset request
    crit_cmd = 1'b1;
    cyc(5);
    chk(16'(motor_stop_q), 16'h0001, "critical stop");
    crit_cmd = 1'b0;
    pulse_clear();
    cyc(2);
    chk(16'(motor_stop_q), 16'h0001, "critical stop after clear");
    do_reset();
    chk(16'(motor_stop_q), 16'h0000, "stop after reset");
    acc(1'b0, IDX_ALARM_EN, 16'h0000, 1'b0, 16'h000B);
    cyc(3);
    chk(16'(exp_q.size()), 16'h0000, "answers missing");
    test_done();
  end
endmodule : tb
